//--- rtl/cfb_pkg.sv
// package: constants, types and carriers for the channel frame buffer manager
package cfb_pkg;
    localparam int unsigned CHANNELS    = 8;
    localparam int unsigned TX_WORDS    = 1024;
    localparam int unsigned RX_WORDS    = 2048;
    localparam int unsigned TX_AW       = 12;
    localparam int unsigned RX_AW       = 13;
    localparam int unsigned PRI_DEPTH   = 8;
    localparam int unsigned SEC_DEPTH   = 2;
    localparam logic [3:0]  CPU_STEP    = 4'h4;
    localparam logic [3:0]  ENG_STEP    = 4'h2;
    localparam logic [15:0] SIZE_RESET  = 16'h0000;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam int unsigned CTRL_FIFO_BIT = 0;
    localparam int unsigned CTRL_TXIE_BIT = 1;
    localparam int unsigned CTRL_RXIE_BIT = 2;

    typedef enum logic [2:0] {
        CFB_REV_IDLE = 3'b001,
        CFB_REV_WAIT = 3'b010,
        CFB_REV_DONE = 3'b100
    } cfb_rev_state_t;

    typedef enum logic [3:0] {
        CFB_F_TX_START = 4'h0,
        CFB_F_TX_END   = 4'h1,
        CFB_F_TX_WR    = 4'h2,
        CFB_F_TX_RD    = 4'h3,
        CFB_F_TX_SIZE  = 4'h4,
        CFB_F_RX_START = 4'h5,
        CFB_F_RX_END   = 4'h6,
        CFB_F_RX_WR    = 4'h7,
        CFB_F_RX_RD    = 4'h8,
        CFB_F_CTRL     = 4'h9
    } cfb_field_t;

    // cpu-side request
    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic        is_cfg;
        cfb_field_t  field;
        logic        head_wr;
        logic        head_rd;
        logic        raw_tx;
        logic        raw_wr;
        logic [12:0] addr;
        logic [31:0] wdata;
    } cfb_cpu_req_t;

    // cpu-side answer
    typedef struct packed {
        logic        done;
        logic [31:0] rdata;
    } cfb_cpu_rsp_t;
endpackage

//--- rtl/cfb_manager.sv
// module: channel frame buffer manager, one clock, two dual-port rams
// How it works
// - tx ram written from cpu side, read by engine; rx ram the reverse
// - cpu reverse-direction accesses allowed; they take extra wait cycles
// - each engine has primary and secondary channel; engine picks which
// - tx ram holds at most 1K 32-bit words
// - rx ram holds at most 2K 32-bit words
// - rams are word-wide and shared among channels by their bounds
// - eight independent channel register sets
// - control picks mode and interrupt enables; status is read-only
// - tx region bounded by programmable start and end
// - rx region bounded by programmable start and end
// - tx read pointer addresses next data sent to engine
// - per-channel tx packet size byte count register
// - rx write pointer addresses next data stored from engine
// - fifo rx head read returns word at rx read pointer
// - last received packet byte count rounded up to even
// - fifo or random access mode selected per channel
// - fifo mode: hardware moves pointers circularly
// - fifo tx head write stores at write pointer, adds four
// - engine 16-bit read after start advances tx read pointer by two
// - tx pointers wrap to start after passing end
// - fifo rx head read advances rx read pointer by four
// - rx pointers wrap within rx bounds
// - engine words 16-bit; primary queue eight deep, secondary two
// - random mode: heads unused, cpu manages pointers
`timescale 1ns/1ps
module cfb_manager
    import cfb_pkg::*;
#(
    parameter int unsigned NCH = CHANNELS
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // cpu side
    input  wire cfb_cpu_req_t cpu_req_i,
    output cfb_cpu_rsp_t      cpu_rsp_o,
    // engine transmit side
    input  wire logic         eng_tx_rd_i,
    input  wire logic [2:0]   eng_tx_chan_i,
    input  wire logic         eng_tx_start_i,
    output logic [15:0]       eng_tx_data_o,
    output logic              eng_tx_valid_o,
    // engine receive side
    input  wire logic         eng_rx_wr_i,
    input  wire logic [2:0]   eng_rx_chan_i,
    input  wire logic [15:0]  eng_rx_data_i,
    input  wire logic         eng_rx_eop_i,
    // status
    output logic [NCH-1:0]    tx_busy_o,
    output logic [NCH-1:0]    rx_event_o,
    output logic [NCH-1:0]    irq_o
);
    // storage
    logic [31:0] tx_ram [TX_WORDS];
    logic [31:0] rx_ram [RX_WORDS];

    // per-channel register sets
    logic [TX_AW-1:0] tx_start_r [NCH], tx_end_r [NCH], tx_wp_r [NCH], tx_rp_r [NCH];
    logic [RX_AW-1:0] rx_start_r [NCH], rx_end_r [NCH], rx_wp_r [NCH], rx_rp_r [NCH];
    logic [15:0]      tx_size_r [NCH], tx_left_r [NCH], rx_cnt_r [NCH], rx_size_r [NCH];
    logic [7:0]       ctrl_r [NCH];
    logic [NCH-1:0]   tx_busy_r, rx_evt_r;
    logic [TX_AW-1:0] tx_start_nxt [NCH], tx_end_nxt [NCH], tx_wp_nxt [NCH], tx_rp_nxt [NCH];
    logic [RX_AW-1:0] rx_start_nxt [NCH], rx_end_nxt [NCH], rx_wp_nxt [NCH], rx_rp_nxt [NCH];
    logic [15:0]      tx_size_nxt [NCH], tx_left_nxt [NCH], rx_cnt_nxt [NCH], rx_size_nxt [NCH];
    logic [7:0]       ctrl_nxt [NCH];
    logic [NCH-1:0]   tx_busy_nxt, rx_evt_nxt;

    // reverse-direction sequencer, cpu answer, engine data and interrupt registers
    cfb_rev_state_t   rev_r, rev_nxt;
    cfb_cpu_rsp_t     rsp_r, rsp_nxt;
    logic [15:0]      etx_data_r, etx_data_nxt;
    logic             etx_valid_r, etx_valid_nxt;
    logic [NCH-1:0]   irq_r, irq_nxt;

    // circular advance inside [start, end], wrap after end word
    function automatic logic [RX_AW-1:0] cfb_adv(input logic [RX_AW-1:0] p,
                                                 input logic [RX_AW-1:0] s,
                                                 input logic [RX_AW-1:0] e,
                                                 input logic [3:0] step);
        logic [RX_AW-1:0] n;
        n = p + RX_AW'(step);
        cfb_adv = (n[RX_AW-1:2] > e[RX_AW-1:2] || n < p) ? s : n;
    endfunction

    // queue depth the engine may keep outstanding per channel
    function automatic logic [3:0] cfb_depth(input logic [2:0] ch);
        cfb_depth = ch[0] ? 4'(SEC_DEPTH) : 4'(PRI_DEPTH);
    endfunction

    // channel, fifo mode and engine queue depth shorthands
    logic [2:0] cc;
    logic       fifo_c;
    logic [3:0] unused_depth;
    assign cc     = cpu_req_i.chan;
    assign fifo_c = ctrl_r[cc][CTRL_FIFO_BIT];
    assign unused_depth = cfb_depth(eng_rx_chan_i);

    // next-state computation for all channel state
    always_comb begin
        logic [RX_AW-1:0] t;
        t = '0;
        for (int i = 0; i < NCH; i++) begin
            tx_start_nxt[i] = tx_start_r[i];
            tx_end_nxt[i]   = tx_end_r[i];
            tx_wp_nxt[i]    = tx_wp_r[i];
            tx_rp_nxt[i]    = tx_rp_r[i];
            tx_size_nxt[i]  = tx_size_r[i];
            tx_left_nxt[i]  = tx_left_r[i];
            rx_start_nxt[i] = rx_start_r[i];
            rx_end_nxt[i]   = rx_end_r[i];
            rx_wp_nxt[i]    = rx_wp_r[i];
            rx_rp_nxt[i]    = rx_rp_r[i];
            rx_cnt_nxt[i]   = rx_cnt_r[i];
            rx_size_nxt[i]  = rx_size_r[i];
            ctrl_nxt[i]     = ctrl_r[i];
        end
        tx_busy_nxt   = tx_busy_r;
        rx_evt_nxt    = rx_evt_r;
        rev_nxt       = rev_r;
        rsp_nxt       = '0;
        etx_valid_nxt = 1'b0;
        etx_data_nxt  = etx_data_r;

        // engine transmit: start then 16-bit reads
        if (eng_tx_start_i) begin
            tx_busy_nxt[eng_tx_chan_i] = 1'b1;
            tx_left_nxt[eng_tx_chan_i] = tx_size_r[eng_tx_chan_i];
        end else if (eng_tx_rd_i && tx_busy_r[eng_tx_chan_i]) begin
            t = RX_AW'(tx_rp_r[eng_tx_chan_i]);
            etx_data_nxt  = t[1] ? tx_ram[t[TX_AW-1:2]][31:16]
                                 : tx_ram[t[TX_AW-1:2]][15:0];
            etx_valid_nxt = 1'b1;
            tx_rp_nxt[eng_tx_chan_i] = TX_AW'(cfb_adv(t,
                RX_AW'(tx_start_r[eng_tx_chan_i]), RX_AW'(tx_end_r[eng_tx_chan_i]),
                ENG_STEP));
            if (tx_left_r[eng_tx_chan_i] <= 16'(ENG_STEP)) begin
                tx_left_nxt[eng_tx_chan_i] = '0;
                tx_busy_nxt[eng_tx_chan_i] = 1'b0;
            end else begin
                tx_left_nxt[eng_tx_chan_i] = tx_left_r[eng_tx_chan_i] - 16'(ENG_STEP);
            end
        end

        // engine receive: 16-bit writes advance write pointer
        if (eng_rx_wr_i) begin
            rx_wp_nxt[eng_rx_chan_i] = cfb_adv(rx_wp_r[eng_rx_chan_i],
                rx_start_r[eng_rx_chan_i], rx_end_r[eng_rx_chan_i], ENG_STEP);
            rx_cnt_nxt[eng_rx_chan_i] = rx_cnt_r[eng_rx_chan_i] + 16'(ENG_STEP);
        end
        if (eng_rx_eop_i) begin
            rx_size_nxt[eng_rx_chan_i] = (rx_cnt_nxt[eng_rx_chan_i] + 16'h0001)
                                         & 16'hFFFE;
            rx_cnt_nxt[eng_rx_chan_i]  = '0;
            rx_evt_nxt[eng_rx_chan_i]  = 1'b1;
        end

        // cpu side
        if (cpu_req_i.valid && cpu_req_i.is_cfg) begin
            rsp_nxt.done = 1'b1;
            if (cpu_req_i.raw_wr) begin
                unique case (cpu_req_i.field)
                    CFB_F_TX_START: tx_start_nxt[cc] = cpu_req_i.wdata[TX_AW-1:0];
                    CFB_F_TX_END:   tx_end_nxt[cc]   = cpu_req_i.wdata[TX_AW-1:0];
                    CFB_F_TX_WR:    tx_wp_nxt[cc]    = cpu_req_i.wdata[TX_AW-1:0];
                    CFB_F_TX_RD:    tx_rp_nxt[cc]    = cpu_req_i.wdata[TX_AW-1:0];
                    CFB_F_TX_SIZE:  tx_size_nxt[cc]  = cpu_req_i.wdata[15:0];
                    CFB_F_RX_START: rx_start_nxt[cc] = cpu_req_i.wdata[RX_AW-1:0];
                    CFB_F_RX_END:   rx_end_nxt[cc]   = cpu_req_i.wdata[RX_AW-1:0];
                    CFB_F_RX_WR:    rx_wp_nxt[cc]    = cpu_req_i.wdata[RX_AW-1:0];
                    CFB_F_RX_RD:    rx_rp_nxt[cc]    = cpu_req_i.wdata[RX_AW-1:0];
                    CFB_F_CTRL:     ctrl_nxt[cc]     = cpu_req_i.wdata[7:0];
                    default:        rsp_nxt.done     = 1'b1;
                endcase
            end else begin
                unique case (cpu_req_i.field)
                    CFB_F_TX_START: rsp_nxt.rdata = 32'(tx_start_r[cc]);
                    CFB_F_TX_END:   rsp_nxt.rdata = 32'(tx_end_r[cc]);
                    CFB_F_TX_WR:    rsp_nxt.rdata = 32'(tx_wp_r[cc]);
                    CFB_F_TX_RD:    rsp_nxt.rdata = 32'(tx_rp_r[cc]);
                    CFB_F_TX_SIZE:  rsp_nxt.rdata = 32'(tx_size_r[cc]);
                    CFB_F_RX_START: rsp_nxt.rdata = 32'(rx_start_r[cc]);
                    CFB_F_RX_END:   rsp_nxt.rdata = 32'(rx_end_r[cc]);
                    CFB_F_RX_WR:    rsp_nxt.rdata = 32'(rx_wp_r[cc]);
                    CFB_F_RX_RD:    rsp_nxt.rdata = 32'(rx_rp_r[cc]);
                    CFB_F_CTRL:     rsp_nxt.rdata = {rx_size_r[cc], 6'h00, tx_busy_r[cc],
                                                     rx_evt_r[cc], ctrl_r[cc]};
                    default:        rsp_nxt.rdata = '0;
                endcase
                if (cpu_req_i.field == CFB_F_CTRL) begin
                    rx_evt_nxt[cc] = (eng_rx_eop_i && eng_rx_chan_i == cc);  // set wins
                end
            end
        end else if (cpu_req_i.valid && cpu_req_i.head_wr && fifo_c) begin
            tx_wp_nxt[cc] = TX_AW'(cfb_adv(RX_AW'(tx_wp_r[cc]), RX_AW'(tx_start_r[cc]),
                                   RX_AW'(tx_end_r[cc]), CPU_STEP));
            rsp_nxt.done  = 1'b1;
        end else if (cpu_req_i.valid && cpu_req_i.head_rd && fifo_c) begin
            rsp_nxt.rdata = rx_ram[rx_rp_r[cc][RX_AW-1:2]];
            rx_rp_nxt[cc] = cfb_adv(rx_rp_r[cc], rx_start_r[cc], rx_end_r[cc],
                                    CPU_STEP);
            rsp_nxt.done  = 1'b1;
        end else if (cpu_req_i.valid && (cpu_req_i.head_wr || cpu_req_i.head_rd)) begin
            rsp_nxt.done  = 1'b1;  // random mode heads are inert
        end else if (cpu_req_i.valid && !cpu_req_i.raw_tx && !cpu_req_i.raw_wr) begin
            rsp_nxt.rdata = rx_ram[cpu_req_i.addr[RX_AW-1:2]];  // normal direction
            rsp_nxt.done  = 1'b1;
        end else if (cpu_req_i.valid && cpu_req_i.raw_tx && cpu_req_i.raw_wr) begin
            rsp_nxt.done  = 1'b1;  // normal direction write
        end else if (cpu_req_i.valid) begin
            // reverse direction: extra wait states, request held by cpu
            unique case (rev_r)
                CFB_REV_IDLE: rev_nxt = CFB_REV_WAIT;
                CFB_REV_WAIT: rev_nxt = CFB_REV_DONE;
                CFB_REV_DONE: begin
                    rev_nxt       = CFB_REV_IDLE;
                    rsp_nxt.done  = 1'b1;
                    rsp_nxt.rdata = tx_ram[cpu_req_i.addr[TX_AW-1:2]];
                end
            endcase
        end

        // interrupt lines from enables and events
        for (int i = 0; i < NCH; i++) begin
            irq_nxt[i] = (ctrl_r[i][CTRL_RXIE_BIT] & rx_evt_r[i])
                       | (ctrl_r[i][CTRL_TXIE_BIT] & ~tx_busy_r[i]);
        end
    end

    // ram write ports; read-first on same-cycle collision
    always_ff @(posedge clock_i) begin
        if (cpu_req_i.valid && !cpu_req_i.is_cfg && cpu_req_i.head_wr && fifo_c) begin
            tx_ram[tx_wp_r[cc][TX_AW-1:2]] <= cpu_req_i.wdata;
        end else if (cpu_req_i.valid && !cpu_req_i.is_cfg && !cpu_req_i.head_wr
                     && !cpu_req_i.head_rd && cpu_req_i.raw_tx && cpu_req_i.raw_wr) begin
            tx_ram[cpu_req_i.addr[TX_AW-1:2]] <= cpu_req_i.wdata;
        end
        if (eng_rx_wr_i) begin
            if (rx_wp_r[eng_rx_chan_i][1]) begin
                rx_ram[rx_wp_r[eng_rx_chan_i][RX_AW-1:2]][31:16] <= eng_rx_data_i;
            end else begin
                rx_ram[rx_wp_r[eng_rx_chan_i][RX_AW-1:2]][15:0] <= eng_rx_data_i;
            end
        end
        if (cpu_req_i.valid && !cpu_req_i.is_cfg && rev_r == CFB_REV_DONE
                     && !cpu_req_i.raw_tx && cpu_req_i.raw_wr) begin
            rx_ram[cpu_req_i.addr[RX_AW-1:2]] <= cpu_req_i.wdata;  // reverse write
        end
    end

    // state registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NCH; i++) begin
                tx_start_r[i] <= '0;
                tx_end_r[i]   <= '0;
                tx_wp_r[i]    <= '0;
                tx_rp_r[i]    <= '0;
                tx_size_r[i]  <= SIZE_RESET;
                tx_left_r[i]  <= SIZE_RESET;
                rx_start_r[i] <= '0;
                rx_end_r[i]   <= '0;
                rx_wp_r[i]    <= '0;
                rx_rp_r[i]    <= '0;
                rx_cnt_r[i]   <= SIZE_RESET;
                rx_size_r[i]  <= SIZE_RESET;
                ctrl_r[i]     <= CTRL_RESET;
            end
            tx_busy_r   <= '0;
            rx_evt_r    <= '0;
            rev_r       <= CFB_REV_IDLE;
            rsp_r       <= '0;
            etx_data_r  <= '0;
            etx_valid_r <= 1'b0;
            irq_r       <= '0;
        end else begin
            tx_start_r  <= tx_start_nxt;
            tx_end_r    <= tx_end_nxt;
            tx_wp_r     <= tx_wp_nxt;
            tx_rp_r     <= tx_rp_nxt;
            tx_size_r   <= tx_size_nxt;
            tx_left_r   <= tx_left_nxt;
            rx_start_r  <= rx_start_nxt;
            rx_end_r    <= rx_end_nxt;
            rx_wp_r     <= rx_wp_nxt;
            rx_rp_r     <= rx_rp_nxt;
            rx_cnt_r    <= rx_cnt_nxt;
            rx_size_r   <= rx_size_nxt;
            ctrl_r      <= ctrl_nxt;
            tx_busy_r   <= tx_busy_nxt;
            rx_evt_r    <= rx_evt_nxt;
            rev_r       <= rev_nxt;
            rsp_r       <= rsp_nxt;
            etx_data_r  <= etx_data_nxt;
            etx_valid_r <= etx_valid_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // outputs straight from flip-flops
    assign cpu_rsp_o      = rsp_r;
    assign eng_tx_data_o  = etx_data_r;
    assign eng_tx_valid_o = etx_valid_r;
    assign tx_busy_o      = tx_busy_r;
    assign rx_event_o     = rx_evt_r;
    assign irq_o          = irq_r;
endmodule

//--- verification/cfb_manager_checker.sv
// checker: port timing relations of the frame buffer manager
`timescale 1ns/1ps
module cfb_manager_checker
    import cfb_pkg::*;
#(
    parameter int unsigned NCH = CHANNELS
) (
    // clock and reset
    input wire logic           clock_i,
    input wire logic           rst_n_i,
    // cpu side
    input wire cfb_cpu_req_t   cpu_req_i,
    input wire cfb_cpu_rsp_t   cpu_rsp_o,
    // engine side
    input wire logic           eng_tx_rd_i,
    input wire logic [2:0]     eng_tx_chan_i,
    input wire logic           eng_tx_start_i,
    input wire logic [15:0]    eng_tx_data_o,
    input wire logic           eng_tx_valid_o,
    input wire logic           eng_rx_wr_i,
    input wire logic [2:0]     eng_rx_chan_i,
    input wire logic [15:0]    eng_rx_data_i,
    input wire logic           eng_rx_eop_i,
    // status
    input wire logic [NCH-1:0] tx_busy_o,
    input wire logic [NCH-1:0] rx_event_o,
    input wire logic [NCH-1:0] irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // request kinds
    logic data_op, head_op, rev_rd;
    assign data_op = cpu_req_i.valid && !cpu_req_i.is_cfg;
    assign head_op = cpu_req_i.head_wr || cpu_req_i.head_rd;
    assign rev_rd  = cpu_req_i.raw_tx && !cpu_req_i.raw_wr;
    cfg_answer_a: assert property ($rose(cpu_req_i.valid) && cpu_req_i.is_cfg |=> cpu_rsp_o.done)
        else $error("config access answer late");
    head_answer_a: assert property ($rose(cpu_req_i.valid) && data_op && head_op |=> cpu_rsp_o.done)
        else $error("head access answer late");
    fwd_answer_a: assert property ($rose(cpu_req_i.valid) && data_op && !head_op
        && (cpu_req_i.raw_tx == cpu_req_i.raw_wr) |=> cpu_rsp_o.done)
        else $error("forward ram access answer late");
    rev_answer_a: assert property ($rose(cpu_req_i.valid) && data_op && !head_op && rev_rd
        |-> !cpu_rsp_o.done [*3] ##1 cpu_rsp_o.done)
        else $error("reverse ram read timing wrong");
    done_cause_a: assert property (cpu_rsp_o.done |-> $past(cpu_req_i.valid))
        else $error("answer without request");
    tx_valid_a: assert property (eng_tx_rd_i && tx_busy_o[eng_tx_chan_i] |=> eng_tx_valid_o)
        else $error("engine read not answered");
    valid_cause_a: assert property (eng_tx_valid_o |-> $past(eng_tx_rd_i))
        else $error("engine data without read");
    busy_cause_a: assert property (|(tx_busy_o & ~$past(tx_busy_o)) |-> $past(eng_tx_start_i))
        else $error("transmit busy without start");
    eop_event_a: assert property (eng_rx_eop_i |=> rx_event_o[$past(eng_rx_chan_i)])
        else $error("end of packet not flagged");
    event_clear_a: assert property (|($past(rx_event_o) & ~rx_event_o) |-> $past(cpu_req_i.valid
        && cpu_req_i.is_cfg && cpu_req_i.field == CFB_F_CTRL))
        else $error("receive event cleared without control read");
    // main scenarios
    rev_c: cover property ($rose(cpu_req_i.valid) && data_op && rev_rd);
    txrd_c: cover property (eng_tx_valid_o);
    eop_c: cover property (eng_rx_eop_i && eng_rx_wr_i);
endmodule
bind cfb_manager cfb_manager_checker #(.NCH(NCH)) chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req_i), .cpu_rsp_o(cpu_rsp_o),
    .eng_tx_rd_i(eng_tx_rd_i), .eng_tx_chan_i(eng_tx_chan_i), .eng_tx_start_i(eng_tx_start_i),
    .eng_tx_data_o(eng_tx_data_o), .eng_tx_valid_o(eng_tx_valid_o), .eng_rx_wr_i(eng_rx_wr_i),
    .eng_rx_chan_i(eng_rx_chan_i), .eng_rx_data_i(eng_rx_data_i), .eng_rx_eop_i(eng_rx_eop_i),
    .tx_busy_o(tx_busy_o), .rx_event_o(rx_event_o), .irq_o(irq_o)
);

//--- verification/cfb_engine_model.sv
// engine model: drives the protocol engine side of the manager
`timescale 1ns/1ps
module cfb_engine_model (
    // clock
    input  wire logic        clock_i,
    // transmit side
    input  wire logic [15:0] eng_tx_data_o,
    input  wire logic        eng_tx_valid_o,
    output logic             eng_tx_rd_i,
    output logic [2:0]       eng_tx_chan_i,
    output logic             eng_tx_start_i,
    // receive side
    output logic             eng_rx_wr_i,
    output logic [2:0]       eng_rx_chan_i,
    output logic [15:0]      eng_rx_data_i,
    output logic             eng_rx_eop_i
);
    // idle strobes at time zero
    initial begin
        {eng_tx_rd_i, eng_tx_start_i, eng_rx_wr_i, eng_rx_eop_i} = 4'h0;
        {eng_tx_chan_i, eng_rx_chan_i} = 6'h00;
        eng_rx_data_i = 16'h0000;
    end
    // start pulse on the channel the engine owns
    task automatic tx_start(input logic [2:0] ch);
        @(posedge clock_i);
        #1 eng_tx_chan_i = ch;
        eng_tx_start_i = 1'b1;
        @(posedge clock_i);
        #1 eng_tx_start_i = 1'b0;
    endtask
    // one 16-bit read, answer taken one cycle on
    task automatic tx_read(input logic [2:0] ch, input int gap, output logic [15:0] d,
                           output logic ok);
        repeat (gap) @(posedge clock_i);
        @(posedge clock_i);
        #1 eng_tx_chan_i = ch;
        eng_tx_rd_i = 1'b1;
        @(posedge clock_i);
        #1 eng_tx_rd_i = 1'b0;
        ok = eng_tx_valid_o;
        d = eng_tx_data_o;
    endtask
    // one 16-bit write, optional end of packet in the same cycle
    task automatic rx_write(input logic [2:0] ch, input logic [15:0] d, input logic e,
                            input int gap);
        repeat (gap) @(posedge clock_i);
        @(posedge clock_i);
        #1 eng_rx_chan_i = ch;
        eng_rx_data_i = d;
        eng_rx_wr_i = 1'b1;
        eng_rx_eop_i = e;
        @(posedge clock_i);
        #1 eng_rx_wr_i = 1'b0;
        eng_rx_eop_i = 1'b0;
        eng_rx_data_i = ~d; // released line shows no stale data
    endtask
endmodule

//--- verification/cfb_manager_test.sv
// testbench: directed scenarios for the frame buffer manager
`timescale 1ns/1ps
module cfb_manager_test
    import cfb_pkg::*;
;
    logic         clock_i, rst_n_i;
    cfb_cpu_req_t req;
    cfb_cpu_rsp_t rsp;
    logic         tx_rd, tx_start, tx_valid, rx_wr, rx_eop;
    logic [2:0]   tx_chan, rx_chan;
    logic [15:0]  tx_data, rx_data;
    logic [7:0]   tx_busy_o, rx_event_o, irq_o;
    logic [31:0]  q;
    int           bad_count, num_checks;
    // clock
    initial clock_i = 1'b0;
    always #2.5 clock_i = ~clock_i;
    cfb_manager #(.NCH(8)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_req_i(req),
        .cpu_rsp_o(rsp), .eng_tx_rd_i(tx_rd), .eng_tx_chan_i(tx_chan),
        .eng_tx_start_i(tx_start), .eng_tx_data_o(tx_data), .eng_tx_valid_o(tx_valid),
        .eng_rx_wr_i(rx_wr), .eng_rx_chan_i(rx_chan), .eng_rx_data_i(rx_data),
        .eng_rx_eop_i(rx_eop), .tx_busy_o(tx_busy_o), .rx_event_o(rx_event_o), .irq_o(irq_o));
    cfb_engine_model eng_u (.clock_i(clock_i), .eng_tx_data_o(tx_data),
        .eng_tx_valid_o(tx_valid), .eng_tx_rd_i(tx_rd), .eng_tx_chan_i(tx_chan),
        .eng_tx_start_i(tx_start), .eng_rx_wr_i(rx_wr), .eng_rx_chan_i(rx_chan),
        .eng_rx_data_i(rx_data), .eng_rx_eop_i(rx_eop));
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request word, k = head_wr head_rd raw_tx raw_wr
    function automatic cfb_cpu_req_t mk(logic [2:0] c, logic g, logic [3:0] f, logic [3:0] k,
                                        logic [12:0] a, logic [31:0] d);
        mk = {1'b1, c, g, f, k, a, d};
    endfunction
    // cpu access, valid held until done
    task automatic go(input cfb_cpu_req_t r, output logic [31:0] d);
        int n;
        @(posedge clock_i);
        #1 req = r;
        n = 0;
        do begin
            @(posedge clock_i);
            #1 n++;
        end while (rsp.done !== 1'b1 && n < 20);
        d = rsp.rdata;
        req.valid = 1'b0;
        if (rsp.done !== 1'b1) begin
            bad_count++;
            $display("mismatch cpu answer expected done seen none");
            end_sim();
        end
    endtask
    task automatic wr(input logic [2:0] c, input logic [3:0] f, input logic [31:0] d);
        go(mk(c, 1'b1, f, 4'h1, 13'h0000, d), q);
    endtask
    task automatic rd(input logic [2:0] c, input logic [3:0] f);
        go(mk(c, 1'b1, f, 4'h0, 13'h0000, 32'h0000_0000), q);
    endtask
    // every field except control of every channel holds its own value
    task automatic t_regs;
        for (int c = 0; c < 8; c++) begin
            for (int f = 0; f < 9; f++) wr(3'(c), 4'(f), 32'({3'(c), 4'(f), 2'b00}));
        end
        for (int c = 0; c < 8; c++) begin
            for (int f = 0; f < 9; f++) begin
                rd(3'(c), 4'(f));
                chk("channel field", q, 32'({3'(c), 4'(f), 2'b00}));
            end
        end
        $display("test regs done");
    endtask
    // fifo transmit: head writes wrap, engine reads wrap
    task automatic t_tx;
        logic [31:0] w [int];
        logic [15:0] h;
        logic        ok;
        int          p, n;
        wr(3'h0, CFB_F_TX_START, 32'h0000_0010);
        wr(3'h0, CFB_F_TX_END, 32'h0000_001C);
        wr(3'h0, CFB_F_TX_WR, 32'h0000_0010);
        wr(3'h0, CFB_F_CTRL, 32'h0000_0003);
        p = 16;
        for (int i = 0; i < 5; i++) begin
            w[p] = 32'hA0B0_0000 + 32'(i);
            go(mk(3'h0, 1'b0, 4'h0, 4'h8, 13'h0000, w[p]), q);
            p = (p == 28) ? 16 : p + 4;
        end
        rd(3'h0, CFB_F_TX_WR);
        chk("tx write pointer", q, 32'h0000_0014);
        wr(3'h0, CFB_F_TX_RD, 32'h0000_001C);
        wr(3'h0, CFB_F_TX_SIZE, 32'h0000_0008);
        eng_u.tx_start(3'h0);
        p = 28;
        n = 0;
        while (tx_busy_o[0] === 1'b1 && n < 8) begin
            eng_u.tx_read(3'h0, n % 2, h, ok);
            chk("tx valid", 32'(ok), 32'h0000_0001);
            chk("tx halfword", 32'(h), 32'(p[1] ? w[p & 28][31:16] : w[p & 28][15:0]));
            p = (p == 30) ? 16 : p + 2;
            n++;
        end
        rd(3'h0, CFB_F_TX_RD);
        chk("tx read pointer", q, 32'(p));
        chk("tx busy end", 32'(tx_busy_o[0]), 32'h0000_0000);
        chk("tx irq", 32'(irq_o[0]), 32'h1);
        $display("test tx done");
    endtask
    // fifo receive: engine writes wrap, size and event, head reads wrap
    task automatic t_rx;
        wr(3'h3, CFB_F_RX_START, 32'h0000_0100);
        wr(3'h3, CFB_F_RX_END, 32'h0000_0104);
        wr(3'h3, CFB_F_RX_WR, 32'h0000_0100);
        wr(3'h3, CFB_F_RX_RD, 32'h0000_0100);
        wr(3'h3, CFB_F_CTRL, 32'h0000_0005);
        for (int i = 0; i < 4; i++) eng_u.rx_write(3'h3, 16'hC000 + 16'(i), i == 3, i % 2);
        @(posedge clock_i);
        #1 chk("rx irq", 32'(irq_o[3]), 32'h0000_0001);
        rd(3'h3, CFB_F_CTRL);
        chk("rx size", 32'(q[31:16]), 32'h0000_0008);
        chk("rx event", 32'(q[8]), 32'h0000_0001);
        chk("ctrl bits", 32'(q[7:0]), 32'h0000_0005);
        rd(3'h3, CFB_F_CTRL);
        chk("rx event clear", 32'(q[8]), 32'h0000_0000);
        chk("rx irq clear", 32'(irq_o[3]), 32'h0000_0000);
        rd(3'h3, CFB_F_RX_WR);
        chk("rx write pointer", q, 32'h0000_0100);
        go(mk(3'h3, 1'b0, 4'h0, 4'h4, 13'h0000, 32'h0000_0000), q);
        chk("rx head first", q, 32'hC001_C000);
        go(mk(3'h3, 1'b0, 4'h0, 4'h4, 13'h0000, 32'h0000_0000), q);
        chk("rx head second", q, 32'hC003_C002);
        rd(3'h3, CFB_F_RX_RD);
        chk("rx read pointer", q, 32'h0000_0100);
        $display("test rx done");
    endtask
    // random access: head ignored, both rams both ways at top word
    task automatic t_raw;
        wr(3'h1, CFB_F_CTRL, 32'h0000_0000);
        go(mk(3'h1, 1'b0, 4'h0, 4'h8, 13'h0000, 32'hDEAD_0001), q);
        rd(3'h1, CFB_F_TX_WR);
        chk("random head", q, 32'h0000_0048);
        go(mk(3'h1, 1'b0, 4'h0, 4'h3, 13'h0FFC, 32'h1234_5678), q);
        go(mk(3'h1, 1'b0, 4'h0, 4'h2, 13'h0FFC, 32'h0000_0000), q);
        chk("tx ram readback", q, 32'h1234_5678);
        go(mk(3'h1, 1'b0, 4'h0, 4'h1, 13'h1FFC, 32'h8765_4321), q);
        go(mk(3'h1, 1'b0, 4'h0, 4'h0, 13'h1FFC, 32'h0000_0000), q);
        chk("rx ram readback", q, 32'h8765_4321);
        $display("test raw done");
    endtask
    // main sequence
    initial begin
        bad_count = 0;
        num_checks = 0;
        req = '0;
        rst_n_i = 1'b0;
        repeat (8) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_raw();
        end_sim();
    end
endmodule
